/* File: aro_bshift.v */
// Left barrel shifter into a double-width result
`default_nettype none
module aro_bshift #(
  parameter DW  = 16,
  parameter SVW = 4
) (
  input  wire [DW-1:0]   data_i,
  input  wire [SVW-1:0]  amt_i,
  input  wire            sext_i,
  output wire [2*DW-1:0] out_o
);
  wire [2*DW-1:0] ext;
  // High half fills with sign copies only in extension mode
  assign ext = {{DW{sext_i & data_i[DW-1]}}, data_i};
  assign out_o = ext << amt_i;
endmodule
`default_nettype wire

/* File: aro_defs.vh */
// Constants for the accumulator reference execution datapath
// Notes on behaviour
// RL1 - Swap bit picks offset accumulator as source
// RL2 - Swap bit exchanges two-operand order
// RL3 - Negate, invert, multiply, barrel use inverted swap
// RL4 - Destination bit picks accumulator or offset
// RL5 - Decode class from 17-bit instruction word
// RL6 - Negate and invert write source, update status
// RL7 - Lookup reads program memory, post-increments pointer
// RL8 - Clear and copy update destination and status
// RL9 - Subtract in selected order, write, update status
// RL10 - Add both accumulators, write, update status
// RL11 - Compare updates status only
// RL12 - Shift left one, carry takes outgoing bit
// RL13 - XOR, OR, AND both accumulators
// RL14 - Shift right one, fill per extension mode
// RL15 - Add or subtract product high, string carry
// RL16 - Move product high, string chains zero flag
// RL17 - Sign fill, string pre-increments accumulator address
// RL18 - String product-high ops and fill execute once
// RL19 - Load shift count or product high
// RL20 - Load multiplier operand, set unsigned flag
// RL21 - Multiply then subtract, add or move low
// RL22 - Barrel shift by shift count, high to PH
// RL23 - Multiply, rounded high into product high
// RL24 - Reserved opcodes do nothing
`ifndef ARO_DEFS_VH
`define ARO_DEFS_VH
`define ARO_CLASS_CODE 5'h1C
`define ARO_OP_NEG     5'h00
`define ARO_OP_INV     5'h01
`define ARO_OP_LOOKUP  5'h02
`define ARO_OP_CLR     5'h03
`define ARO_OP_SUB     5'h04
`define ARO_OP_ADD     5'h05
`define ARO_OP_SHL1    5'h06
`define ARO_OP_COPY    5'h07
`define ARO_OP_XOR     5'h08
`define ARO_OP_OR      5'h09
`define ARO_OP_AND     5'h0A
`define ARO_OP_SHR1    5'h0B
`define ARO_OP_PHSUB   5'h0C
`define ARO_OP_PHADD   5'h0D
`define ARO_OP_PHMOV   5'h0E
`define ARO_OP_SFILL   5'h0F
`define ARO_OP_CMP     5'h10
`define ARO_OP_LDSV    5'h14
`define ARO_OP_LDPH    5'h15
`define ARO_OP_LDMR    5'h16
`define ARO_OP_LDMRU   5'h17
`define ARO_OP_MULSUB  5'h18
`define ARO_OP_MULADD  5'h19
`define ARO_OP_BMOV    5'h1A
`define ARO_OP_MULMOV  5'h1B
`define ARO_OP_BSUB    5'h1C
`define ARO_OP_BADD    5'h1D
`define ARO_OP_MULRND  5'h1E
`define ARO_OP_BHIGH   5'h1F
`define ARO_ROUND_ADD  32'h00008000
`define ARO_REG_PH     3'h0
`define ARO_REG_SV     3'h1
`define ARO_REG_MR     3'h2
`define ARO_REG_DP     3'h3
`define ARO_REG_STAT   3'h4
`define ARO_STAT_CF    0
`define ARO_STAT_ZF    1
`define ARO_STAT_SF    2
`define ARO_STAT_UM    3
`define ARO_STAT_XM    4
`define ARO_RST_WORD   16'h0000
`endif

/* File: aro_exec.v */
// Accumulator reference execution datapath top level
`include "aro_defs.vh"
`default_nettype none
module aro_exec #(
  parameter DW  = 16,
  parameter SVW = 4
) (
  input  wire          mclk_i,
  input  wire          rst_b_i,
  input  wire          issue_i,
  input  wire [16:0]   instr_i,
  input  wire [DW-1:0] acc_i,
  input  wire [DW-1:0] offs_i,
  input  wire          string_mode_i,
  input  wire [DW-1:0] pmem_data_i,
  input  wire [2:0]    reg_addr_i,
  input  wire [DW-1:0] reg_wdata_i,
  input  wire          reg_wr_i,
  input  wire          reg_rd_i,
  output reg  [DW-1:0] reg_rdata_o,
  output wire          busy_o,
  output reg           done_o,
  output reg  [DW-1:0] res_o,
  output reg           res_wr_o,
  output reg           res_offs_o,
  output reg  [1:0]    next_ptr_o,
  output reg  [1:0]    acc_pointer_index_o,
  output reg           once_o,
  output reg           preinc_o,
  output reg  [DW-1:0] pmem_addr_o,
  output reg           pmem_rd_o
);
  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  reg rst_meta_b;
  reg rst_sync_b;
  always @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_meta_b <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta_b <= 1'b1;
      rst_sync_b <= rst_meta_b;
    end
  end

  // ----------------------------------------
  // State and registers
  // ----------------------------------------
  localparam ST_IDLE  = 3'b001;
  localparam ST_FETCH = 3'b010;
  localparam ST_WAIT  = 3'b100;
  reg [2:0]     state;
  reg [DW-1:0]  product_high_reg;
  reg [SVW-1:0] shift_count_reg;
  reg [DW-1:0]  multiplier_operand_reg;
  reg [DW-1:0]  lookup_pointer_reg;
  reg           carry_flag;
  reg           zero_flag;
  reg           sign_flag;
  reg           unsigned_multiply_flag;
  reg           sign_extension_mode;
  reg           pend_offs;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  wire [4:0]    class_opcode_field;
  wire          src_swap;
  wire          dst_sel;
  wire          hit;
  wire          rev;
  wire          pick_offs;
  wire [DW-1:0] src;
  wire [DW-1:0] oth;
  wire          lk_done;
  assign busy_o = ~state[0];
  assign class_opcode_field = instr_i[7:3];
  assign src_swap = instr_i[1];
  assign dst_sel = instr_i[0];
  // RL5 class match
  assign hit = issue_i & ~busy_o & (instr_i[16:12] == `ARO_CLASS_CODE) & ~instr_i[2];
  // RL3 inverted polarity ops
  assign rev = (class_opcode_field == `ARO_OP_NEG) |
               (class_opcode_field == `ARO_OP_INV) |
               (class_opcode_field[4:3] == 2'b11);
  // RL1 RL2 source and operand order
  assign pick_offs = src_swap ^ rev;
  assign src = pick_offs ? offs_i : acc_i;
  assign oth = pick_offs ? acc_i : offs_i;
  assign lk_done = state[2];

  // ----------------------------------------
  // Multiplier, shifter, adder
  // ----------------------------------------
  wire [2*DW-1:0] prod;
  wire [2*DW-1:0] prod_rnd;
  wire [2*DW-1:0] bsh;
  aro_mul #(.DW(DW)) u_mul (
    .mr_i   (multiplier_operand_reg),
    .src_i  (src),
    .uns_i  (unsigned_multiply_flag),
    .prod_o (prod)
  );
  aro_bshift #(.DW(DW), .SVW(SVW)) u_bsh (
    .data_i (src),
    .amt_i  (shift_count_reg),
    .sext_i (sign_extension_mode),
    .out_o  (bsh)
  );
  // RL23 rounding before taking the high half
  assign prod_rnd = prod + `ARO_ROUND_ADD;

  wire          ph_op;
  wire          strg;
  wire          ad_sub;
  wire          ad_cin;
  wire [DW-1:0] ad_a;
  wire [DW-1:0] ad_b;
  wire [DW:0]   ad_sum;
  assign ph_op = (class_opcode_field == `ARO_OP_PHSUB) |
                 (class_opcode_field == `ARO_OP_PHADD);
  assign strg = string_mode_i & ph_op;
  assign ad_sub = (class_opcode_field == `ARO_OP_SUB) |
                  (class_opcode_field == `ARO_OP_CMP) |
                  (class_opcode_field == `ARO_OP_NEG) |
                  (class_opcode_field == `ARO_OP_PHSUB) |
                  (class_opcode_field == `ARO_OP_MULSUB) |
                  (class_opcode_field == `ARO_OP_BSUB);
  // RL15 string carry feeds the adder
  assign ad_cin = strg ? carry_flag : ad_sub;
  assign ad_a = (class_opcode_field == `ARO_OP_NEG) ? {DW{1'b0}} :
                (class_opcode_field[4:3] == 2'b11) ? oth : src;
  assign ad_b = (class_opcode_field == `ARO_OP_NEG) ? src :
                ph_op ? product_high_reg :
                (class_opcode_field == `ARO_OP_MULSUB) ? prod[DW-1:0] :
                (class_opcode_field == `ARO_OP_MULADD) ? prod[DW-1:0] :
                (class_opcode_field[4:3] == 2'b11) ? bsh[DW-1:0] : oth;
  // Carry out reads as no-borrow on subtraction
  assign ad_sum = {1'b0, ad_a} + {1'b0, ad_sub ? ~ad_b : ad_b} + {{DW{1'b0}}, ad_cin};

  // ----------------------------------------
  // Operation select
  // ----------------------------------------
  reg [DW-1:0] next_res;
  reg          next_wr;
  reg          next_alu;
  reg          next_cf;
  reg          next_zchain;
  reg          next_xfer;
  reg          next_ph_ld;
  reg [DW-1:0] next_ph;
  reg          next_sv_ld;
  reg          next_mr_ld;
  reg          next_um;
  reg          next_once;
  reg          next_preinc;
  always @* begin
    next_res = {DW{1'b0}};
    next_wr = 1'b0;
    next_alu = 1'b0;
    next_cf = carry_flag;
    next_zchain = 1'b0;
    next_xfer = 1'b0;
    next_ph_ld = 1'b0;
    next_ph = product_high_reg;
    next_sv_ld = 1'b0;
    next_mr_ld = 1'b0;
    next_um = unsigned_multiply_flag;
    next_once = 1'b0;
    next_preinc = 1'b0;
    case (class_opcode_field)
      // RL6 two's and one's complement
      `ARO_OP_NEG: begin
        next_res = ad_sum[DW-1:0];
        next_cf = ad_sum[DW];
        next_wr = 1'b1;
        next_alu = 1'b1;
      end
      `ARO_OP_INV: begin
        next_res = ~src;
        next_wr = 1'b1;
        next_alu = 1'b1;
      end
      // RL8 clear and copy
      `ARO_OP_CLR: begin
        next_wr = 1'b1;
        next_alu = 1'b1;
      end
      `ARO_OP_COPY: begin
        next_res = src;
        next_wr = 1'b1;
        next_alu = 1'b1;
      end
      // RL9 RL10 subtract and add
      `ARO_OP_SUB, `ARO_OP_ADD: begin
        next_res = ad_sum[DW-1:0];
        next_cf = ad_sum[DW];
        next_wr = 1'b1;
        next_alu = 1'b1;
      end
      // RL11 flags only
      `ARO_OP_CMP: begin
        next_res = ad_sum[DW-1:0];
        next_cf = ad_sum[DW];
        next_alu = 1'b1;
      end
      // RL12 shift left one
      `ARO_OP_SHL1: begin
        next_res = {src[DW-2:0], 1'b0};
        next_cf = src[DW-1];
        next_wr = 1'b1;
        next_alu = 1'b1;
      end
      // RL13 bitwise logic
      `ARO_OP_XOR: begin
        next_res = acc_i ^ offs_i;
        next_wr = 1'b1;
        next_alu = 1'b1;
      end
      `ARO_OP_OR: begin
        next_res = acc_i | offs_i;
        next_wr = 1'b1;
        next_alu = 1'b1;
      end
      `ARO_OP_AND: begin
        next_res = acc_i & offs_i;
        next_wr = 1'b1;
        next_alu = 1'b1;
      end
      // RL14 shift right one
      `ARO_OP_SHR1: begin
        next_res = {sign_extension_mode & src[DW-1], src[DW-1:1]};
        next_wr = 1'b1;
        next_alu = 1'b1;
      end
      // RL15 RL18 product high add or subtract
      `ARO_OP_PHSUB, `ARO_OP_PHADD: begin
        next_res = ad_sum[DW-1:0];
        next_cf = ad_sum[DW];
        next_wr = 1'b1;
        next_alu = 1'b1;
        next_zchain = string_mode_i;
        next_once = string_mode_i;
      end
      // RL16 RL18 product high move
      `ARO_OP_PHMOV: begin
        next_res = product_high_reg;
        next_wr = 1'b1;
        next_alu = 1'b1;
        next_zchain = string_mode_i;
        next_once = string_mode_i;
      end
      // RL17 RL18 sign fill
      `ARO_OP_SFILL: begin
        next_res = {DW{sign_flag}};
        next_wr = 1'b1;
        next_once = string_mode_i;
        next_preinc = string_mode_i;
      end
      // RL19 shift count and product high loads
      `ARO_OP_LDSV: begin
        next_sv_ld = 1'b1;
        next_xfer = 1'b1;
      end
      `ARO_OP_LDPH: begin
        next_ph_ld = 1'b1;
        next_ph = src;
        next_xfer = 1'b1;
      end
      // RL20 multiplier operand loads
      `ARO_OP_LDMR, `ARO_OP_LDMRU: begin
        next_mr_ld = 1'b1;
        next_um = class_opcode_field[0];
        next_xfer = 1'b1;
      end
      // RL21 multiply then combine low half
      `ARO_OP_MULSUB, `ARO_OP_MULADD: begin
        next_res = ad_sum[DW-1:0];
        next_cf = ad_sum[DW];
        next_wr = 1'b1;
        next_alu = 1'b1;
        next_ph_ld = 1'b1;
        next_ph = prod[2*DW-1:DW];
      end
      `ARO_OP_MULMOV: begin
        next_res = prod[DW-1:0];
        next_wr = 1'b1;
        next_alu = 1'b1;
        next_ph_ld = 1'b1;
        next_ph = prod[2*DW-1:DW];
      end
      // RL22 barrel shift variants
      `ARO_OP_BSUB, `ARO_OP_BADD: begin
        next_res = ad_sum[DW-1:0];
        next_cf = ad_sum[DW];
        next_wr = 1'b1;
        next_alu = 1'b1;
        next_ph_ld = 1'b1;
        next_ph = bsh[2*DW-1:DW];
      end
      `ARO_OP_BMOV: begin
        next_res = bsh[DW-1:0];
        next_wr = 1'b1;
        next_alu = 1'b1;
        next_ph_ld = 1'b1;
        next_ph = bsh[2*DW-1:DW];
      end
      `ARO_OP_BHIGH: begin
        next_ph_ld = 1'b1;
        next_ph = bsh[2*DW-1:DW];
      end
      // RL23 rounded high half only
      `ARO_OP_MULRND: begin
        next_ph_ld = 1'b1;
        next_ph = prod_rnd[2*DW-1:DW];
      end
      // RL24 reserved opcodes and lookup fall here
      default: begin
        next_wr = 1'b0;
      end
    endcase
  end

  // ----------------------------------------
  // Sequencing and results
  // ----------------------------------------
  wire is_lk;
  wire go;
  assign is_lk = hit & (class_opcode_field == `ARO_OP_LOOKUP);
  assign go = hit & ~is_lk;
  always @(posedge mclk_i or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      state <= ST_IDLE;
      done_o <= 1'b0;
      res_o <= `ARO_RST_WORD;
      res_wr_o <= 1'b0;
      res_offs_o <= 1'b0;
      next_ptr_o <= 2'h0;
      acc_pointer_index_o <= 2'h0;
      once_o <= 1'b0;
      preinc_o <= 1'b0;
      pmem_addr_o <= `ARO_RST_WORD;
      pmem_rd_o <= 1'b0;
      pend_offs <= 1'b0;
    end else begin
      done_o <= go | lk_done;
      res_wr_o <= (go & next_wr) | lk_done;
      once_o <= go & next_once;
      preinc_o <= go & next_preinc;
      pmem_rd_o <= is_lk;
      if (hit) begin
        next_ptr_o <= instr_i[11:10];
        acc_pointer_index_o <= instr_i[9:8];
      end
      // RL4 destination select
      if (go) begin
        res_o <= next_res;
        res_offs_o <= dst_sel;
      end
      case (state)
        ST_IDLE: begin
          // RL7 address comes from the source
          if (is_lk) begin
            state <= ST_FETCH;
            pmem_addr_o <= src;
            pend_offs <= dst_sel;
          end
        end
        ST_FETCH: begin
          state <= ST_WAIT;
        end
        ST_WAIT: begin
          state <= ST_IDLE;
          res_o <= pmem_data_i;
          res_offs_o <= pend_offs;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Working registers and status
  // ----------------------------------------
  wire next_z;
  assign next_z = (next_res == {DW{1'b0}});
  always @(posedge mclk_i or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      product_high_reg <= `ARO_RST_WORD;
      shift_count_reg <= {SVW{1'b0}};
      multiplier_operand_reg <= `ARO_RST_WORD;
      lookup_pointer_reg <= `ARO_RST_WORD;
      carry_flag <= 1'b0;
      zero_flag <= 1'b0;
      sign_flag <= 1'b0;
      unsigned_multiply_flag <= 1'b0;
      sign_extension_mode <= 1'b0;
    end else begin
      // Software writes first so a same-cycle instruction update wins
      if (reg_wr_i) begin
        case (reg_addr_i)
          `ARO_REG_PH: product_high_reg <= reg_wdata_i;
          `ARO_REG_SV: shift_count_reg <= reg_wdata_i[SVW-1:0];
          `ARO_REG_MR: multiplier_operand_reg <= reg_wdata_i;
          `ARO_REG_STAT: begin
            carry_flag <= reg_wdata_i[`ARO_STAT_CF];
            zero_flag <= reg_wdata_i[`ARO_STAT_ZF];
            sign_flag <= reg_wdata_i[`ARO_STAT_SF];
            unsigned_multiply_flag <= reg_wdata_i[`ARO_STAT_UM];
            sign_extension_mode <= reg_wdata_i[`ARO_STAT_XM];
          end
          default: begin
            carry_flag <= carry_flag;
          end
        endcase
      end
      if (go) begin
        if (next_ph_ld) product_high_reg <= next_ph;
        // RL19 count takes low bits
        if (next_sv_ld) shift_count_reg <= src[SVW-1:0];
        // RL20 operand and mode
        if (next_mr_ld) begin
          multiplier_operand_reg <= src;
          unsigned_multiply_flag <= next_um;
        end
        // RL16 zero chained across string
        if (next_alu) begin
          carry_flag <= next_cf;
          zero_flag <= next_zchain ? (zero_flag & next_z) : next_z;
          sign_flag <= next_res[DW-1];
        end
        if (next_xfer) begin
          zero_flag <= (src == {DW{1'b0}});
          sign_flag <= src[DW-1];
        end
      end
      // RL7 pointer post-increment
      if (is_lk) lookup_pointer_reg <= src + {{(DW-1){1'b0}}, 1'b1};
      // RL7 status from fetched word
      if (lk_done) begin
        zero_flag <= (pmem_data_i == {DW{1'b0}});
        sign_flag <= pmem_data_i[DW-1];
      end
    end
  end

  // ----------------------------------------
  // Register read port
  // ----------------------------------------
  always @(posedge mclk_i or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      reg_rdata_o <= `ARO_RST_WORD;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `ARO_REG_PH: reg_rdata_o <= product_high_reg;
        `ARO_REG_SV: reg_rdata_o <= {{(DW-SVW){1'b0}}, shift_count_reg};
        `ARO_REG_MR: reg_rdata_o <= multiplier_operand_reg;
        `ARO_REG_DP: reg_rdata_o <= lookup_pointer_reg;
        `ARO_REG_STAT: reg_rdata_o <= {{(DW-5){1'b0}}, sign_extension_mode,
          unsigned_multiply_flag, sign_flag, zero_flag, carry_flag};
        default: reg_rdata_o <= `ARO_RST_WORD;
      endcase
    end else begin
      // Data stand only in the cycle after the strobe
      reg_rdata_o <= `ARO_RST_WORD;
    end
  end
endmodule
`default_nettype wire

/* File: aro_exec_props.sv */
// Assertion checker bound to the accumulator reference datapath
`include "aro_defs.vh"
`default_nettype none
module aro_exec_props #(
  parameter DW  = 16,
  parameter SVW = 4
) (
  input wire logic          mclk_i,
  input wire logic          rst_b_i,
  input wire logic          issue_i,
  input wire logic [16:0]   instr_i,
  input wire logic [DW-1:0] acc_i,
  input wire logic [DW-1:0] offs_i,
  input wire logic [DW-1:0] pmem_data_i,
  input wire logic          busy_o,
  input wire logic          done_o,
  input wire logic [DW-1:0] res_o,
  input wire logic          res_wr_o,
  input wire logic          res_offs_o,
  input wire logic [1:0]    next_ptr_o,
  input wire logic [1:0]    acc_pointer_index_o,
  input wire logic [DW-1:0] pmem_addr_o,
  input wire logic          pmem_rd_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Taken instruction and its opcode
  // ----------------------------------------
  wire logic       take = issue_i && !busy_o && (instr_i[16:12] == `ARO_CLASS_CODE) && !instr_i[2];
  wire logic [4:0] op   = instr_i[7:3];
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  a_done_next: assert property (take && op != `ARO_OP_LOOKUP |=> done_o)
    else $error("done missing after instruction");
  a_foreign_quiet: assert property (issue_i && !busy_o && instr_i[16:12] != 5'h1C |=> !done_o)
    else $error("done after foreign word");
  a_add_sum: assert property (take && op == `ARO_OP_ADD |=>
    res_wr_o && res_o == $past(acc_i) + $past(offs_i))
    else $error("add result wrong");
  a_sub_order: assert property (take && op == `ARO_OP_SUB |=> res_o == ($past(instr_i[1]) ?
    $past(offs_i) - $past(acc_i) : $past(acc_i) - $past(offs_i)))
    else $error("subtract order wrong");
  a_neg_swap: assert property (take && op == `ARO_OP_NEG |=> res_o == ({DW{1'b0}} -
    ($past(instr_i[1]) ? $past(acc_i) : $past(offs_i))))
    else $error("negate source wrong");
  a_dest_route: assert property (take && op != `ARO_OP_LOOKUP |=>
    res_offs_o == $past(instr_i[0]))
    else $error("destination select wrong");
  a_cmp_quiet: assert property (take && (op == `ARO_OP_CMP || (op > 5'h10 && op < 5'h14)) |=>
    done_o && !res_wr_o)
    else $error("compare or reserved wrote result");
  a_lookup_fetch: assert property (take && op == `ARO_OP_LOOKUP |=> pmem_rd_o && busy_o &&
    pmem_addr_o == ($past(instr_i[1]) ? $past(offs_i) : $past(acc_i)))
    else $error("lookup address wrong");
  a_lookup_done: assert property (take && op == `ARO_OP_LOOKUP |=> !done_o ##1 !done_o ##1
    (done_o && res_wr_o && res_o == $past(pmem_data_i)))
    else $error("lookup data not delivered");
  a_ptr_capture: assert property (take |=> next_ptr_o == $past(instr_i[11:10]) &&
    acc_pointer_index_o == $past(instr_i[9:8]))
    else $error("pointer fields not captured");
  a_shl_one: assert property (take && op == `ARO_OP_SHL1 |=>
    res_o == (($past(instr_i[1]) ? $past(offs_i) : $past(acc_i)) << 1))
    else $error("shift left result wrong");
endmodule
bind aro_exec aro_exec_props #(.DW(DW), .SVW(SVW)) u_props (.mclk_i, .rst_b_i, .issue_i,
  .instr_i, .acc_i, .offs_i, .pmem_data_i, .busy_o, .done_o, .res_o, .res_wr_o, .res_offs_o,
  .next_ptr_o, .acc_pointer_index_o, .pmem_addr_o, .pmem_rd_o);
`default_nettype wire

/* File: aro_mul.v */
// Signed or unsigned multiplier for the operand register
`default_nettype none
module aro_mul #(
  parameter DW = 16
) (
  input  wire [DW-1:0]   mr_i,
  input  wire [DW-1:0]   src_i,
  input  wire            uns_i,
  output wire [2*DW-1:0] prod_o
);
  // Operand register widened by one bit so unsigned mode shares the signed array
  wire signed [DW:0]     op_a;
  wire signed [DW:0]     op_b;
  wire signed [2*DW+1:0] prod_full;
  assign op_a = {(~uns_i) & mr_i[DW-1], mr_i};
  assign op_b = {src_i[DW-1], src_i};
  assign prod_full = op_a * op_b;
  assign prod_o = prod_full[2*DW-1:0];
endmodule
`default_nettype wire

/* File: tb.sv */
// Self-checking bench for the accumulator reference datapath
`include "aro_defs.vh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [7:0]  op;
    logic [3:0]  sd;
    logic [15:0] a;
    logic [15:0] o;
    logic [15:0] r;
    logic [3:0]  wr;
  } aro_row_t;
  logic             mclk_i, rst_b_i, issue_i, string_mode_i, reg_wr_i, reg_rd_i;
  logic [16:0]      instr_i;
  logic [15:0]      acc_i, offs_i, pmem_data_i, reg_wdata_i, rdv;
  logic [2:0]       reg_addr_i;
  wire logic [15:0] reg_rdata_o, res_o, pmem_addr_o;
  wire logic        busy_o, done_o, res_wr_o, res_offs_o, once_o, preinc_o, pmem_rd_o;
  wire logic [1:0]  next_ptr_o, acc_pointer_index_o;
  int               n_errors, checked, cycles;
  // Order matters: flags, PH, SV and MR carry from row to row
  aro_row_t rows [0:40] = '{
    64'h05_0_0003_0004_0007_1, 64'h05_1_FFFF_0002_0001_1, 64'h04_0_0005_0003_0002_1,
    64'h04_3_0005_0003_FFFE_1, 64'h00_0_0005_0003_FFFD_1, 64'h00_2_0001_0003_FFFF_1,
    64'h0F_0_0000_0000_FFFF_1, 64'h01_1_00FF_0F0F_F0F0_1, 64'h07_2_1111_2222_2222_1,
    64'h03_1_1234_5678_0000_1, 64'h08_0_0FF0_00FF_0F0F_1, 64'h09_0_0FF0_00FF_0FFF_1,
    64'h0A_0_0FF0_00FF_00F0_1, 64'h06_0_8001_0000_0002_1, 64'h0B_2_0000_8004_4002_1,
    64'h10_0_0005_0005_0000_0, 64'h11_0_0005_0001_0000_0, 64'h12_0_0005_0001_0000_0,
    64'h13_0_0005_0001_0000_0, 64'h15_0_1234_0000_0000_0, 64'h0E_0_0000_0000_1234_1,
    64'h14_2_0000_0004_0000_0, 64'h1A_2_1234_0000_2340_1, 64'h0E_0_0000_0000_0001_1,
    64'h0D_2_0000_0010_0011_1, 64'h16_0_0003_0000_0000_0, 64'h1B_0_0000_FFFE_FFFA_1,
    64'h0E_0_0000_0000_FFFF_1, 64'h0C_0_0010_0000_0011_1, 64'h19_0_0010_0002_0016_1,
    64'h1D_2_0001_0005_0015_1, 64'h1F_2_F000_0000_0000_0, 64'h0E_0_0000_0000_000F_1,
    64'h17_0_FFFF_0000_0000_0, 64'h1B_0_0000_0002_FFFE_1, 64'h0E_0_0000_0000_0001_1,
    64'h1E_0_0000_4000_0000_0, 64'h0E_0_0000_0000_4000_1, 64'h18_0_0000_0001_0001_1,
    64'h1C_2_0001_0030_0020_1, 64'h0E_0_0000_0000_0000_1};

  aro_exec dut_u (.mclk_i, .rst_b_i, .issue_i, .instr_i, .acc_i, .offs_i, .string_mode_i,
    .pmem_data_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .busy_o,
    .done_o, .res_o, .res_wr_o, .res_offs_o, .next_ptr_o, .acc_pointer_index_o, .once_o,
    .preinc_o, .pmem_addr_o, .pmem_rd_o);

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk_w(input string name, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s exp %h got %h", name, exp, got);
    end
  endtask
  task automatic chk_b(input string name, input logic exp, input logic got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s exp %b got %b", name, exp, got);
    end
  endtask
  task automatic stop_test();
    $display("Counts: %0d checked, %0d bad", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Issue one word; returns 1 ns after the edge that takes it
  task automatic run(input logic [4:0] op, input logic [1:0] sd, input logic sm,
                     input logic [15:0] a, input logic [15:0] o);
    @(posedge mclk_i);
    issue_i       <= 1'b1;
    instr_i       <= {5'h1C, 4'h6, op, 1'b0, sd};
    acc_i         <= a;
    offs_i        <= o;
    string_mode_i <= sm;
    @(posedge mclk_i);
    issue_i <= 1'b0;
    #1;
  endtask
  task automatic wr_reg(input logic [2:0] ad, input logic [15:0] d);
    @(posedge mclk_i);
    reg_wr_i    <= 1'b1;
    reg_addr_i  <= ad;
    reg_wdata_i <= d;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd_reg(input logic [2:0] ad);
    @(posedge mclk_i);
    reg_rd_i   <= 1'b1;
    reg_addr_i <= ad;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    #1;
    rdv = reg_rdata_o;
  endtask

  initial begin
    mclk_i = 1'b0;
    forever #12.5 mclk_i = ~mclk_i;
  end
  // Hang guard, well above the roughly 126 cycles the run needs
  always @(posedge mclk_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_errors++;
      stop_test();
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {rst_b_i, issue_i, string_mode_i, reg_wr_i, reg_rd_i} = 5'h00;
    {instr_i, acc_i, offs_i, reg_wdata_i, reg_addr_i} = '0;
    pmem_data_i = 16'h5A5A;
    repeat (3) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    foreach (rows[i]) begin
      run(rows[i].op[4:0], rows[i].sd[1:0], 1'b0, rows[i].a, rows[i].o);
      chk_b("done", 1'b1, done_o);
      chk_b("write", rows[i].wr[0], res_wr_o);
      chk_w("ptr", 16'h0016, {12'h001, next_ptr_o, acc_pointer_index_o});
      if (rows[i].wr) begin
        chk_w("result", rows[i].r, res_o);
        chk_b("dest", rows[i].sd[0], res_offs_o);
      end
    end
    $display("Table test done");
    run(5'h06, 2'h0, 1'b0, 16'h8001, 16'h0000);
    rd_reg(3'h4);
    chk_b("carry", 1'b1, rdv[0]);
    wr_reg(3'h4, 16'h0010);
    run(5'h0B, 2'h0, 1'b0, 16'h8000, 16'h0000);
    chk_w("sign shift", 16'hC000, res_o);
    wr_reg(3'h0, 16'hA5A5);
    rd_reg(3'h0);
    chk_w("ph", 16'hA5A5, rdv);
    rd_reg(3'h7);
    chk_w("unmapped", 16'h0000, rdv);
    $display("Flag and register test done");
    // Lookup, with an add held on issue while busy that must be dropped
    @(posedge mclk_i);
    issue_i <= 1'b1;
    instr_i <= {5'h1C, 4'h6, 5'h02, 3'h3};
    acc_i   <= 16'h7777;
    offs_i  <= 16'h0123;
    @(posedge mclk_i);
    instr_i <= {5'h1C, 4'h6, 5'h05, 3'h0};
    #1;
    chk_b("busy", 1'b1, busy_o);
    chk_w("lookup addr", 16'h0123, pmem_addr_o);
    @(posedge mclk_i);
    issue_i     <= 1'b0;
    pmem_data_i <= 16'hBEEF;
    #1;
    chk_b("refused add", 1'b0, done_o);
    @(posedge mclk_i);
    pmem_data_i <= 16'h4110;
    #1;
    chk_b("lookup done", 1'b1, done_o);
    chk_w("lookup data", 16'hBEEF, res_o);
    wr_reg(3'h3, 16'hFFFF);
    rd_reg(3'h3);
    chk_w("lookup ptr", 16'h0124, rdv);
    $display("Lookup test done");
    run(5'h0E, 2'h0, 1'b1, 16'h0000, 16'h0000);
    chk_b("once", 1'b1, once_o);
    run(5'h0F, 2'h0, 1'b1, 16'h0000, 16'h0000);
    chk_b("preinc", 1'b1, preinc_o);
    chk_b("once fill", 1'b1, once_o);
    run(5'h05, 2'h0, 1'b0, 16'h0001, 16'h0001);
    @(posedge mclk_i);
    instr_i <= {5'h1D, 12'h028};
    issue_i <= 1'b1;
    @(posedge mclk_i);
    issue_i <= 1'b0;
    #1;
    chk_b("foreign", 1'b0, done_o);
    $display("String and foreign test done");
    @(posedge mclk_i);
    rst_b_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    #1;
    chk_w("reset res", 16'h0000, res_o);
    chk_b("reset done", 1'b0, done_o);
    repeat (3) @(posedge mclk_i);
    run(5'h05, 2'h1, 1'b0, 16'h0002, 16'h0003);
    chk_w("after reset", 16'h0005, res_o);
    $display("Reset test done");
    stop_test();
  end
endmodule
`default_nettype wire
